// file: logic/nfc_params.svh
// Timing counts, opcodes and address-field positions for the host controller.
`ifndef NFC_PARAMS_SVH
`define NFC_PARAMS_SVH
// ----------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------
`define NFC_OP_READ 8'h00
`define NFC_OP_READ_GO 8'h30
`define NFC_OP_READ_CB 8'h35
`define NFC_OP_READ_ID 8'h90
`define NFC_OP_RESET 8'hFF
`define NFC_OP_PROG 8'h80
`define NFC_OP_PROG_GO 8'h10
`define NFC_OP_CACHE_GO 8'h15
`define NFC_OP_PLANE_NEXT 8'h11
`define NFC_OP_PROG_LEG2 8'h81
`define NFC_OP_RAND_IN 8'h85
`define NFC_OP_ERASE 8'h60
`define NFC_OP_ERASE_GO 8'hD0
`define NFC_OP_ERASE_NEXT 8'hD1
`define NFC_OP_STATUS 8'h70
`define NFC_OP_STATUS_ENH 8'h78
`define NFC_OP_RAND_OUT 8'h05
`define NFC_OP_RAND_OUT_GO 8'hE0
`define NFC_OP_CACHE_SEQ 8'h31
`define NFC_OP_CACHE_END 8'h3F
`define NFC_OP_PARAM 8'hEC
// ----------------------------------------------------------------------
// Address layout
// ----------------------------------------------------------------------
`define NFC_ADDR_CYCLES 3'd5
`define NFC_COL_W8 12
`define NFC_COL_W16 11
`define NFC_PAGE_W 6
`define NFC_BLOCK_W 13
`define NFC_ROW_W 19
// ----------------------------------------------------------------------
// Strobe timing, in core_clk cycles of 25 ns
// ----------------------------------------------------------------------
`define NFC_CLK_NS 25
`define NFC_STROBE_NS 25
`define NFC_STROBE_CYC \
  ((`NFC_STROBE_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_READ_ACCESS_NS 45
`define NFC_READ_ACCESS_CYC \
  ((`NFC_READ_ACCESS_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_FIFO_DEPTH 32
`endif

// file: logic/nfc_pkg.sv
// Types shared by the host controller modules.
package nfc_pkg;
  typedef enum logic [3:0] {
    NFC_KIND_READ = 4'h0,
    NFC_KIND_PROG = 4'h1,
    NFC_KIND_ERASE = 4'h2,
    NFC_KIND_STATUS = 4'h3,
    NFC_KIND_ID = 4'h4,
    NFC_KIND_RESET = 4'h5,
    NFC_KIND_PARAM = 4'h6
  } nfc_kind_t;
  typedef enum logic [5:0] {
    NFC_ST_IDLE = 6'h01,
    NFC_ST_SETUP = 6'h02,
    NFC_ST_LOW = 6'h04,
    NFC_ST_HIGH = 6'h08,
    NFC_ST_WAIT = 6'h10,
    NFC_ST_DONE = 6'h20
  } nfc_state_t;
  typedef enum logic [1:0] {
    NFC_CYC_CMD = 2'h0,
    NFC_CYC_ADDR = 2'h1,
    NFC_CYC_DIN = 2'h2,
    NFC_CYC_DOUT = 2'h3
  } nfc_cyc_t;
endpackage

// file: logic/nfc_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
`timescale 1ns/100ps
module nfc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;
  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
    next_count = (AW+1)'(count + {AW'(0), push} - {AW'(0), pop});
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
endmodule

// file: logic/nfc_addr_pack.sv
// Splits a column and row address into the five address bus bytes.
`timescale 1ns/100ps
`include "nfc_params.svh"
module nfc_addr_pack (
  input wire logic wide,
  input wire logic [11:0] column,
  input wire logic [`NFC_ROW_W-1:0] row,
  input wire logic [2:0] index,
  output logic [7:0] addr_byte
);
  // Row is page, then plane/block bits running up to its top bit.
  always_comb begin
    addr_byte = 8'h00;
    unique case (index)
      3'd0: addr_byte = column[7:0];
      3'd1: addr_byte = wide ? {5'h00, column[10:8]} : {4'h0, column[11:8]};
      3'd2: addr_byte = row[7:0];
      3'd3: addr_byte = row[15:8];
      3'd4: addr_byte = {5'h00, row[18:16]};
      default: addr_byte = 8'h00;
    endcase
  end
endmodule

// file: logic/nfc_host.sv
// Host-side NAND flash controller driving the multiplexed strobe bus.
//
// Contract
// - Bus value is set up before the write strobe rises.
// - Command cycle: command latch high, address latch low, selected.
// - Address cycle: address latch high, command latch low, selected.
// - Byte-wide address is five cycles with zero-filled upper bits.
// - Word-wide address is five cycles with an 11-bit column.
// - While busy only reset, status and enhanced status are issued.
// - Data input needs both latches low and write protect high.
// - Commands and addresses travel on bus bits 0 to 7.
`timescale 1ns/100ps
`include "nfc_params.svh"
module nfc_host #(
  parameter int DATA_W = 16,
  parameter int FIFO_DEPTH = `NFC_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic wide,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [3:0] req_kind,
  input wire logic [1:0] req_variant,
  input wire logic [11:0] req_column,
  input wire logic [`NFC_ROW_W-1:0] req_row,
  input wire logic [11:0] req_count,
  input wire logic protect,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [DATA_W-1:0] wr_data,
  output logic rd_valid,
  output logic [DATA_W-1:0] rd_data,
  output logic busy,
  output logic done,
  output logic cmd_latch,
  output logic addr_latch,
  output logic chip_sel_n,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic write_protect_n,
  output logic [DATA_W-1:0] io_bus_out,
  output logic io_bus_oe,
  input wire logic [DATA_W-1:0] io_bus_in,
  input wire logic ready_busy_n
);
  // --------------------------------------------------------------------
  // Sequence steps
  // --------------------------------------------------------------------
  // Each step is a kind of bus cycle plus an opcode; an operation is a
  // short list of steps chosen from the request kind and variant.
  localparam int STEPS = 8;
  localparam int HOLD = `NFC_STROBE_CYC;
  localparam int ACC = `NFC_READ_ACCESS_CYC;
  typedef struct packed {
    nfc_pkg::nfc_cyc_t cyc;
    logic [7:0] op;
    logic wait_rdy;
  } nfc_step_t;

  function automatic nfc_step_t stp(nfc_pkg::nfc_cyc_t c, logic [7:0] o,
                                     logic w);
    nfc_step_t s;
    s.cyc = c;
    s.op = o;
    s.wait_rdy = w;
    return s;
  endfunction

  function automatic nfc_step_t cmd(logic [7:0] o, logic w);
    return stp(nfc_pkg::NFC_CYC_CMD, o, w);
  endfunction

  nfc_step_t plan [STEPS];
  logic [2:0] plan_len;
  logic [2:0] step, next_step;
  logic [2:0] abyte, next_abyte;
  logic [11:0] left, next_left;
  logic [3:0] tmr, next_tmr;
  nfc_pkg::nfc_state_t state, next_state;
  nfc_pkg::nfc_kind_t kind, next_kind;
  logic [1:0] variant, next_variant;
  logic [11:0] column, next_column;
  logic [`NFC_ROW_W-1:0] row, next_row;
  logic [11:0] count, next_count;
  logic [7:0] addr_byte;
  logic modify;
  logic f_valid, f_ready;
  logic [DATA_W-1:0] f_data;
  logic next_cl, next_al, next_ce_n, next_we_n, next_re_n, next_oe;
  logic next_done, next_rd_valid;
  logic [DATA_W-1:0] next_bus, next_rd_data;

  // Write data passes through a FIFO so the source can run ahead.
  nfc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .srst(srst),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_data),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  nfc_addr_pack u_pack (
    .wide(wide),
    .column(column),
    .row(row),
    .index(abyte),
    .addr_byte(addr_byte)
  );

  // --------------------------------------------------------------------
  // Operation plans
  // --------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < STEPS; i++) begin
      plan[i] = cmd(8'h00, 1'b0);
    end
    plan_len = 3'd1;
    unique case (kind)
      nfc_pkg::NFC_KIND_READ: begin
        plan[0] = cmd(`NFC_OP_READ, 1'b0);
        plan[1] = stp(nfc_pkg::NFC_CYC_ADDR, 8'h00, 1'b0);
        plan[2] = cmd(variant == 2'd1 ? `NFC_OP_READ_CB :
                      variant == 2'd2 ? `NFC_OP_CACHE_SEQ :
                      `NFC_OP_READ_GO, 1'b1);
        plan[3] = stp(nfc_pkg::NFC_CYC_DOUT, 8'h00, 1'b0);
        plan_len = 3'd4;
      end
      nfc_pkg::NFC_KIND_PROG: begin
        plan[0] = cmd(variant[1] ? `NFC_OP_RAND_IN : `NFC_OP_PROG, 1'b0);
        plan[1] = stp(nfc_pkg::NFC_CYC_ADDR, 8'h00, 1'b0);
        plan[2] = stp(nfc_pkg::NFC_CYC_DIN, 8'h00, 1'b0);
        plan[3] = cmd(variant[0] ? `NFC_OP_CACHE_GO : `NFC_OP_PROG_GO,
                      1'b1);
        plan_len = 3'd4;
      end
      nfc_pkg::NFC_KIND_ERASE: begin
        plan[0] = cmd(`NFC_OP_ERASE, 1'b0);
        plan[1] = stp(nfc_pkg::NFC_CYC_ADDR, 8'h00, 1'b0);
        plan[2] = cmd(variant[0] ? `NFC_OP_ERASE_NEXT : `NFC_OP_ERASE_GO,
                      1'b1);
        plan_len = 3'd3;
      end
      nfc_pkg::NFC_KIND_STATUS: begin
        plan[0] = cmd(variant[0] ? `NFC_OP_STATUS_ENH : `NFC_OP_STATUS,
                      1'b0);
        plan[1] = stp(nfc_pkg::NFC_CYC_DOUT, 8'h00, 1'b0);
        plan_len = 3'd2;
      end
      nfc_pkg::NFC_KIND_ID, nfc_pkg::NFC_KIND_PARAM: begin
        plan[0] = cmd(kind == nfc_pkg::NFC_KIND_ID ? `NFC_OP_READ_ID :
                      `NFC_OP_PARAM, 1'b0);
        plan[1] = stp(nfc_pkg::NFC_CYC_ADDR, 8'h00, 1'b1);
        plan[2] = stp(nfc_pkg::NFC_CYC_DOUT, 8'h00, 1'b0);
        plan_len = 3'd3;
      end
      nfc_pkg::NFC_KIND_RESET: begin
        plan[0] = cmd(`NFC_OP_RESET, 1'b1);
        plan_len = 3'd1;
      end
      default: plan_len = 3'd0;
    endcase
  end

  // --------------------------------------------------------------------
  // Bus sequencer
  // --------------------------------------------------------------------
  always_comb begin
    modify = (kind == nfc_pkg::NFC_KIND_PROG) ||
             (kind == nfc_pkg::NFC_KIND_ERASE);
    next_state = state;
    next_step = step;
    next_abyte = abyte;
    next_left = left;
    next_tmr = tmr;
    next_kind = kind;
    next_variant = variant;
    next_column = column;
    next_row = row;
    next_count = count;
    next_cl = cmd_latch;
    next_al = addr_latch;
    next_ce_n = chip_sel_n;
    next_we_n = write_strobe_n;
    next_re_n = read_strobe_n;
    next_oe = io_bus_oe;
    next_bus = io_bus_out;
    next_done = 1'b0;
    next_rd_valid = 1'b0;
    next_rd_data = rd_data;
    f_ready = 1'b0;
    unique case (state)
      nfc_pkg::NFC_ST_IDLE: begin
        next_ce_n = 1'b1;
        next_oe = 1'b0;
        // Only reset and status may go out while the line shows busy.
        if (req_valid && (ready_busy_n ||
            req_kind == nfc_pkg::NFC_KIND_RESET ||
            req_kind == nfc_pkg::NFC_KIND_STATUS)) begin
          next_kind = nfc_pkg::nfc_kind_t'(req_kind);
          next_variant = req_variant;
          next_column = req_column;
          next_row = req_row;
          next_count = req_count;
          next_step = 3'd0;
          // A refused modify op still ends with done so the caller moves on.
          if (protect && (req_kind == 4'(nfc_pkg::NFC_KIND_PROG) ||
              req_kind == 4'(nfc_pkg::NFC_KIND_ERASE))) begin
            next_state = nfc_pkg::NFC_ST_DONE;
          end else begin
            next_state = nfc_pkg::NFC_ST_SETUP;
          end
        end
      end
      nfc_pkg::NFC_ST_SETUP: begin
        next_ce_n = 1'b0;
        next_tmr = 4'(HOLD);
        next_abyte = 3'd0;
        next_left = count;
        if (step == plan_len) begin
          next_state = nfc_pkg::NFC_ST_DONE;
        end else begin
          unique case (plan[step].cyc)
            nfc_pkg::NFC_CYC_CMD: begin
              next_cl = 1'b1;
              next_al = 1'b0;
              next_oe = 1'b1;
              next_bus = DATA_W'(plan[step].op);
            end
            nfc_pkg::NFC_CYC_ADDR: begin
              next_cl = 1'b0;
              next_al = 1'b1;
              next_oe = 1'b1;
            end
            nfc_pkg::NFC_CYC_DIN: begin
              next_cl = 1'b0;
              next_al = 1'b0;
              next_oe = 1'b1;
            end
            nfc_pkg::NFC_CYC_DOUT: begin
              next_cl = 1'b0;
              next_al = 1'b0;
              next_oe = 1'b0;
            end
          endcase
          next_state = nfc_pkg::NFC_ST_LOW;
        end
      end
      nfc_pkg::NFC_ST_LOW: begin
        // Latches and any command byte were set one cycle earlier; address and data bytes go out with the strobe fall.
        if (plan[step].cyc == nfc_pkg::NFC_CYC_ADDR) begin
          next_bus = DATA_W'(addr_byte);
        end else if (plan[step].cyc == nfc_pkg::NFC_CYC_DIN && f_valid) begin
          next_bus = f_data;
          f_ready = 1'b1;
        end
        if (plan[step].cyc == nfc_pkg::NFC_CYC_DOUT) begin
          next_re_n = 1'b0;
          next_tmr = 4'(ACC);
          next_state = nfc_pkg::NFC_ST_HIGH;
        end else if (plan[step].cyc != nfc_pkg::NFC_CYC_DIN || f_valid) begin
          next_we_n = 1'b0;
          next_state = nfc_pkg::NFC_ST_HIGH;
        end
      end
      nfc_pkg::NFC_ST_HIGH: begin
        if (tmr > 4'd1) begin
          next_tmr = 4'(tmr - 4'd1);
        end else begin
          next_tmr = 4'(HOLD);
          next_we_n = 1'b1;
          if (!read_strobe_n) begin
            next_re_n = 1'b1;
            next_rd_data = io_bus_in;
            next_rd_valid = 1'b1;
          end
          if (plan[step].cyc == nfc_pkg::NFC_CYC_ADDR &&
              abyte != `NFC_ADDR_CYCLES - 3'd1) begin
            next_abyte = 3'(abyte + 3'd1);
            next_state = nfc_pkg::NFC_ST_LOW;
          end else if ((plan[step].cyc == nfc_pkg::NFC_CYC_DIN ||
                        plan[step].cyc == nfc_pkg::NFC_CYC_DOUT) &&
                       left > 12'd1) begin
            next_left = 12'(left - 12'd1);
            next_state = nfc_pkg::NFC_ST_LOW;
          end else begin
            // Latches stay up one more cycle as hold after the strobe rises.
            next_state = plan[step].wait_rdy ? nfc_pkg::NFC_ST_WAIT :
                         nfc_pkg::NFC_ST_SETUP;
            next_step = 3'(step + 3'd1);
          end
        end
      end
      nfc_pkg::NFC_ST_WAIT: begin
        next_oe = 1'b0;
        next_cl = 1'b0;
        next_al = 1'b0;
        if (tmr != 4'd0) begin
          next_tmr = 4'(tmr - 4'd1);
        end else if (ready_busy_n) begin
          next_state = nfc_pkg::NFC_ST_SETUP;
        end
      end
      nfc_pkg::NFC_ST_DONE: begin
        next_ce_n = 1'b1;
        next_oe = 1'b0;
        next_done = 1'b1;
        next_cl = 1'b0;
        next_al = 1'b0;
        next_state = nfc_pkg::NFC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= nfc_pkg::NFC_ST_IDLE;
      step <= 3'd0;
      abyte <= 3'd0;
      left <= 12'd0;
      tmr <= 4'd0;
      kind <= nfc_pkg::NFC_KIND_READ;
      variant <= 2'd0;
      column <= 12'd0;
      row <= '0;
      count <= 12'd0;
      cmd_latch <= 1'b0;
      addr_latch <= 1'b0;
      chip_sel_n <= 1'b1;
      write_strobe_n <= 1'b1;
      read_strobe_n <= 1'b1;
      io_bus_oe <= 1'b0;
      io_bus_out <= '0;
      done <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= '0;
      req_ready <= 1'b0;
      busy <= 1'b0;
      write_protect_n <= 1'b0;
    end else begin
      state <= next_state;
      step <= next_step;
      abyte <= next_abyte;
      left <= next_left;
      tmr <= next_tmr;
      kind <= next_kind;
      variant <= next_variant;
      column <= next_column;
      row <= next_row;
      count <= next_count;
      cmd_latch <= next_cl;
      addr_latch <= next_al;
      chip_sel_n <= next_ce_n;
      write_strobe_n <= next_we_n;
      read_strobe_n <= next_re_n;
      io_bus_oe <= next_oe;
      io_bus_out <= next_bus;
      done <= next_done;
      rd_valid <= next_rd_valid;
      rd_data <= next_rd_data;
      req_ready <= (next_state == nfc_pkg::NFC_ST_IDLE);
      busy <= !ready_busy_n;
      // Protect is lifted only for modify operations that software allows.
      write_protect_n <= !protect && modify &&
                         next_state != nfc_pkg::NFC_ST_IDLE;
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  latch_excl_a: assert property (@(posedge core_clk) disable iff (srst)
    !(cmd_latch && addr_latch)) else $error("both latches high");
  cmd_setup_a: assert property (@(posedge core_clk) disable iff (srst)
    $rose(write_strobe_n) && cmd_latch |-> $stable(io_bus_out) &&
    io_bus_oe) else $error("command bus moved at strobe");
  addr_cyc_a: assert property (@(posedge core_clk) disable iff (srst)
    $fell(write_strobe_n) && addr_latch |-> !cmd_latch && !chip_sel_n &&
    read_strobe_n && io_bus_out[DATA_W-1:8] == '0)
    else $error("bad address cycle");
  rd_float_a: assert property (@(posedge core_clk) disable iff (srst)
    !read_strobe_n |-> !io_bus_oe) else $error("host drives in read");
  din_wp_a: assert property (@(posedge core_clk) disable iff (srst)
    $fell(write_strobe_n) && !cmd_latch && !addr_latch |->
    write_protect_n) else $error("data with protect low");
  wp_hold_a: assert property (@(posedge core_clk) disable iff (srst)
    protect |=> !write_protect_n) else $error("protect ignored");
  rd_pulse_a: assert property (@(posedge core_clk) disable iff (srst)
    $fell(read_strobe_n) |-> !read_strobe_n [*2] ##1 read_strobe_n)
    else $error("read strobe width");
  busy_gate_a: assert property (@(posedge core_clk) disable iff (srst)
    state == nfc_pkg::NFC_ST_IDLE && req_valid && !ready_busy_n &&
    req_kind == 4'(nfc_pkg::NFC_KIND_ERASE) |=>
    state == nfc_pkg::NFC_ST_IDLE) else $error("issued while busy");
  cv_prog_c: cover property (@(posedge core_clk)
    kind == nfc_pkg::NFC_KIND_PROG && done);
  cv_read_c: cover property (@(posedge core_clk) rd_valid);
  cv_erase_c: cover property (@(posedge core_clk)
    kind == nfc_pkg::NFC_KIND_ERASE && done);
endmodule

// file: test/nfc_dev_model.sv
// Behavioural NAND flash device facing the host controller.
`timescale 1ns/100ps
module nfc_dev_model (
  input wire logic core_clk,
  input wire logic cmd_latch,
  input wire logic addr_latch,
  input wire logic chip_sel_n,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic write_protect_n,
  input wire logic [15:0] io_bus,
  output logic [15:0] dev_bus,
  output logic ready_busy_n
);
  logic [7:0] cmd_q[$];
  logic [7:0] adr_q[$];
  logic [15:0] din_q[$];
  logic [15:0] word = 16'h0000;
  logic [15:0] bus_d = 16'h0000;
  logic [4:0] pin_d = 5'h1F;
  logic drive = 1'b0;
  logic more = 1'b0;
  int busy_cnt = 0;
  int bad_cmd = 0;
  // A released bus shows the inverse of the last word, so a host that
  // samples it outside a read cannot match by luck.
  assign dev_bus = drive ? word : ~word;
  assign ready_busy_n = (busy_cnt == 0);
  always @(posedge core_clk) begin
    if (busy_cnt > 0)
      busy_cnt <= busy_cnt - 1;
    // Pin copies hold we, cs_n, re, cl, al from before the rising edge.
    if (write_strobe_n && !pin_d[4] && !pin_d[3] && pin_d[2]) begin
      drive <= 1'b0;
      more <= 1'b0;
      if (pin_d[1] && !pin_d[0]) begin
        cmd_q.push_back(bus_d[7:0]);
        word <= {bus_d[7:0], 8'h00};
        if (busy_cnt > 0 && !(bus_d[7:0] inside {8'hFF, 8'h70, 8'h78}))
          bad_cmd <= bad_cmd + 1;
        if (bus_d[7:0] inside {8'h30, 8'h35, 8'h31, 8'h3F, 8'hFF})
          busy_cnt <= 12;
        if (bus_d[7:0] inside {8'h10, 8'h15, 8'hD0} && write_protect_n)
          busy_cnt <= 30;
      end else if (pin_d[0] && !pin_d[1]) begin
        adr_q.push_back(bus_d[7:0]);
      end else if (!pin_d[0] && !pin_d[1] && write_protect_n) begin
        din_q.push_back(bus_d);
      end
    end
    if (!read_strobe_n && pin_d[2] && !chip_sel_n) begin
      drive <= 1'b1;
      more <= 1'b1;
      if (more)
        word <= word + 16'h0001;
    end
    if (chip_sel_n)
      drive <= 1'b0;
    bus_d <= io_bus;
    pin_d <= {write_strobe_n, chip_sel_n, read_strobe_n, cmd_latch,
      addr_latch};
  end
endmodule

// file: test/nfc_host_tb.sv
// Self-checking bench for the host controller against a device model.
`timescale 1ns/100ps
module nfc_host_tb;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic wide = 1'b1;
  logic protect = 1'b0;
  logic req_valid = 1'b0;
  logic [3:0] req_kind = 4'h0;
  logic [1:0] req_variant = 2'h0;
  logic [11:0] req_column = 12'h000;
  logic [18:0] req_row = 19'h00000;
  logic [11:0] req_count = 12'h001;
  logic wr_valid = 1'b0;
  logic [15:0] wr_data = 16'h0000;
  logic req_ready, wr_ready, rd_valid, busy, done, io_bus_oe;
  logic cmd_latch, addr_latch, chip_sel_n, write_strobe_n;
  logic read_strobe_n, write_protect_n, ready_busy_n;
  logic [15:0] rd_data, io_bus_out, dev_bus, io_bus;
  logic [15:0] rd_q[$];
  logic busy_seen = 1'b0;
  int compares = 0;
  int miscompares = 0;
  int cycles = 0;
  // The wire level is worked out from both drivers.
  assign io_bus = io_bus_oe ? io_bus_out : dev_bus;
  nfc_host u_nfc_host (.core_clk, .srst, .wide, .req_valid, .req_ready,
    .req_kind, .req_variant, .req_column, .req_row, .req_count, .protect,
    .wr_valid, .wr_ready, .wr_data, .rd_valid, .rd_data, .busy, .done,
    .cmd_latch, .addr_latch, .chip_sel_n, .write_strobe_n, .read_strobe_n,
    .write_protect_n, .io_bus_out, .io_bus_oe, .io_bus_in(io_bus),
    .ready_busy_n);
  nfc_dev_model u_nfc_dev_model (.core_clk, .cmd_latch, .addr_latch,
    .chip_sel_n, .write_strobe_n, .read_strobe_n, .write_protect_n,
    .io_bus, .dev_bus, .ready_busy_n);
  initial forever #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (busy === 1'b1)
      busy_seen <= 1'b1;
    if (rd_valid === 1'b1)
      rd_q.push_back(rd_data);
    if (cycles == 60000) begin
      miscompares++;
      end_sim();
    end
  end
  // ----------------------------------------------------------------
  // Compare and drive helpers
  // ----------------------------------------------------------------
  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: word %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: flag %b expected %b", $time, g, e);
    end
  endtask
  function automatic logic [7:0] ab(input logic w, input logic [11:0] c,
      input logic [18:0] r, input int i);
    case (i)
      0: return c[7:0];
      1: return w ? {5'h00, c[10:8]} : {4'h0, c[11:8]};
      2: return r[7:0];
      3: return r[15:8];
      default: return {5'h00, r[18:16]};
    endcase
  endfunction
  task automatic chk_addr(input logic [11:0] c, input logic [18:0] r);
    chk_word(16'(u_nfc_dev_model.adr_q.size()), 16'h0005);
    for (int i = 0; i < 5; i++)
      chk_word({8'h00, u_nfc_dev_model.adr_q[i]},
        {8'h00, ab(wide, c, r, i)});
  endtask
  task automatic chk_cmd(input logic [7:0] f, input logic [7:0] l);
    chk_word({8'h00, u_nfc_dev_model.cmd_q[0]}, {8'h00, f});
    chk_word({8'h00, u_nfc_dev_model.cmd_q[$]}, {8'h00, l});
  endtask
  task automatic fill(input int n, input logic [15:0] b);
    int t;
    for (int i = 0; i < n; i++) begin
      @(negedge core_clk);
      wr_data = b + 16'(i);
      wr_valid = 1'b1;
      t = 0;
      do begin
        @(posedge core_clk);
        t++;
      end while (wr_ready !== 1'b1 && t < 50);
    end
    @(negedge core_clk);
    wr_valid = 1'b0;
  endtask
  task automatic run(input logic [3:0] k, input logic [1:0] v,
      input logic [11:0] c, input logic [18:0] r, input logic [11:0] n);
    int t;
    u_nfc_dev_model.cmd_q.delete();
    u_nfc_dev_model.adr_q.delete();
    u_nfc_dev_model.din_q.delete();
    rd_q.delete();
    @(negedge core_clk);
    busy_seen = 1'b0;
    req_kind = k;
    req_variant = v;
    req_column = c;
    req_row = r;
    req_count = n;
    req_valid = 1'b1;
    t = 0;
    // A busy line holds all but reset and status requests in idle, so ready alone is not a take.
    do begin
      @(posedge core_clk);
      t++;
    end while ((req_ready !== 1'b1 || ready_busy_n !== 1'b1) && t < 3000);
    @(negedge core_clk);
    req_valid = 1'b0;
    t = 0;
    while (done !== 1'b1 && t < 3000) begin
      @(posedge core_clk);
      t++;
    end
    chk_bit(done, 1'b1);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk_bit(chip_sel_n, 1'b1);
    chk_bit(write_protect_n, 1'b0);
    chk_bit(io_bus_oe, 1'b0);
    chk_bit(req_ready, 1'b0);
  endtask
  task automatic t_read();
    run(4'h0, 2'h0, 12'h5A3, 19'h51234, 12'h003);
    chk_cmd(8'h00, 8'h30);
    chk_addr(12'h5A3, 19'h51234);
    chk_bit(busy_seen, 1'b1);
    for (int i = 0; i < 3; i++)
      chk_word(rd_q[i], 16'h3000 + 16'(i));
  endtask
  task automatic t_read_forms();
    run(4'h0, 2'h1, 12'h001, 19'h00080, 12'h001);
    chk_cmd(8'h00, 8'h35);
    run(4'h0, 2'h2, 12'h001, 19'h00080, 12'h001);
    chk_word({8'h00, u_nfc_dev_model.cmd_q[$]}, 16'h0031);
  endtask
  task automatic t_prog_x8();
    @(negedge core_clk);
    wide = 1'b0;
    fill(2, 16'h00A1);
    run(4'h1, 2'h0, 12'hBCD, 19'h70F0F, 12'h002);
    chk_cmd(8'h80, 8'h10);
    chk_addr(12'hBCD, 19'h70F0F);
    chk_word({8'h00, u_nfc_dev_model.din_q[1][7:0]}, 16'h00A2);
    chk_bit(busy_seen, 1'b1);
    @(negedge core_clk);
    wide = 1'b1;
  endtask
  task automatic t_prog_forms();
    for (int v = 1; v < 4; v++) begin
      fill(1, 16'h0055);
      run(4'h1, 2'(v), 12'h000, 19'h00041, 12'h001);
      chk_cmd(v > 1 ? 8'h85 : 8'h80, v[0] ? 8'h15 : 8'h10);
    end
  endtask
  task automatic t_protect();
    @(negedge core_clk);
    protect = 1'b1;
    run(4'h1, 2'h0, 12'h000, 19'h00100, 12'h001);
    chk_word(16'(u_nfc_dev_model.din_q.size()), 16'h0000);
    chk_word(16'(u_nfc_dev_model.cmd_q.size()), 16'h0000);
    chk_bit(busy_seen, 1'b0);
    @(negedge core_clk);
    protect = 1'b0;
  endtask
  task automatic t_erase();
    // The line starts busy, so the erase must wait in idle until ready.
    @(negedge core_clk);
    u_nfc_dev_model.busy_cnt = 20;
    run(4'h2, 2'h0, 12'h000, 19'h45678, 12'h001);
    chk_bit(busy_seen, 1'b1);
    chk_cmd(8'h60, 8'hD0);
    run(4'h2, 2'h1, 12'h000, 19'h45638, 12'h001);
    chk_cmd(8'h60, 8'hD1);
  endtask
  task automatic t_misc();
    logic [3:0] k[5] = '{4'h3, 4'h3, 4'h4, 4'h5, 4'h6};
    logic [7:0] op[5] = '{8'h70, 8'h78, 8'h90, 8'hFF, 8'hEC};
    for (int i = 0; i < 5; i++) begin
      run(k[i], i == 1 ? 2'h1 : 2'h0, 12'h000, 19'h00000, 12'h001);
      chk_word({8'h00, u_nfc_dev_model.cmd_q[0]}, {8'h00, op[i]});
      if (i < 2)
        chk_word(rd_q[0], {op[i], 8'h00});
    end
  endtask
  task automatic t_fifo();
    fill(32, 16'h1200);
    @(negedge core_clk);
    wr_valid = 1'b1;
    repeat (2) @(posedge core_clk);
    chk_bit(wr_ready, 1'b0);
    @(negedge core_clk);
    wr_valid = 1'b0;
    run(4'h1, 2'h0, 12'h010, 19'h00040, 12'h020);
    chk_word(16'(u_nfc_dev_model.din_q.size()), 16'h0020);
    chk_word(u_nfc_dev_model.din_q[31], 16'h121F);
    chk_bit(wr_ready, 1'b1);
  endtask
  task automatic end_sim();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge core_clk);
    t_reset();
    srst = 1'b0;
    t_read();
    t_read_forms();
    t_prog_x8();
    t_prog_forms();
    t_protect();
    t_erase();
    t_misc();
    t_fifo();
    chk_word(16'(u_nfc_dev_model.bad_cmd), 16'h0000);
    end_sim();
  end
endmodule
